// file: hdl/diag_pkg.sv
/*
 holds offsets, reset values, patterns and timing counts of the diagnostic
 and watchdog block; assumes a 10 MHz pclk and a 32-bit APB master
*/
package diag_pkg;
   // apb byte offsets
   localparam logic [7:0] CMD_OFS     = 8'h00;
   localparam logic [7:0] MODE_OFS    = 8'h04;
   localparam logic [7:0] CFG_LO_OFS  = 8'h08;
   localparam logic [7:0] CFG_HI_OFS  = 8'h0c;
   localparam logic [7:0] STATB_OFS   = 8'h10;
   localparam logic [7:0] RIDX_OFS    = 8'h14;
   localparam logic [7:0] RDATA_OFS   = 8'h18;
   localparam logic [7:0] TSTAT_OFS   = 8'h1c;
   // command bit positions in the command register
   localparam int CMD_CLR_CELL = 0;
   localparam int CMD_CLR_AUX  = 1;
   localparam int CMD_CLR_STAT = 2;
   localparam int CMD_ST_CELL  = 3;
   localparam int CMD_ST_AUX   = 4;
   localparam int CMD_ST_STAT  = 5;
   localparam int CMD_OPENW    = 6;
   localparam int CMD_CONV     = 7;
   localparam int CMD_WRITE_CONFIG_CMD    = 8;
   // result word indices
   localparam int NWORDS   = 22;
   localparam int AUX_BASE = 12;
   localparam int STA_BASE = 18;
   localparam logic [15:0] CLEARED_WORD = 16'hffff;
   // self-test patterns per mode
   localparam logic [15:0] PAT1_27K  = 16'h9565;
   localparam logic [15:0] PAT1_14K  = 16'h9553;
   localparam logic [15:0] PAT1_SLOW = 16'h9555;
   localparam logic [15:0] PAT2_27K  = 16'h6a9a;
   localparam logic [15:0] PAT2_14K  = 16'h6aac;
   localparam logic [15:0] PAT2_SLOW = 16'h6aaa;
   localparam logic [2:0]  MODE_27K  = 3'h0;
   localparam logic [2:0]  MODE_14K  = 3'h1;
   // reset values
   localparam logic [31:0] CFG_LO_RST = 32'h0000_0000;
   localparam logic [15:0] CFG_HI_RST = 16'h0000;
   localparam logic [3:0]  REV_VALUE  = 4'h1; // arbitrary value
   localparam logic [1:0]  RSVD_VALUE = 2'h0;
   // timing
   localparam int CLK_HZ        = 10_000_000;
   localparam int TICK_MS       = 1;
   localparam int TICK_CYC      = CLK_HZ / 1000 * TICK_MS;
   localparam int WDOG_S        = 2;
   localparam int WDOG_TICKS    = WDOG_S * 1000 / TICK_MS;
   localparam int HALFMIN_TICKS = 30 * 1000 / TICK_MS;
   localparam int CONV_BASE_CYC = 16;
   // discharge durations in half minutes, code 0 disabled
   localparam logic [7:0] DISCHARGE_TIMEOUT_CODE_HALFMIN [16] = '{8'h00, 8'h01, 8'h02, 8'h04,
      8'h06, 8'h08, 8'h0a, 8'h14, 8'h1e, 8'h28, 8'h3c, 8'h50, 8'h78, 8'h96,
      8'hb4, 8'hf0};
endpackage : diag_pkg

// file: hdl/monitor_diag_watchdog_discharge_timer.sv
/*
 diagnostic and housekeeping logic of a cell monitor: self-test patterns,
 result clearing, status flags, open-wire currents, watchdog and discharge
 timer; assumes an APB master on pclk and asynchronous pins
*/
// Our own choices: register access over APB and the register offsets.
// Function
// - self-test uses the test stream and the normal conversion time and registers
// - pattern choice 01 gives 9565, 9553, else 9555 by mode
// - pattern choice 10 gives 6a9a, 6aac, else 6aaa by mode
// - clear cell results sets all cell result bytes to ff
// - clear aux results sets all aux result bytes to ff
// - clear status sets sum, heat, supply words to ff, keeps revision
// - clear status sets all cell flags, decoder fail and thermal flag
// - thermal flag clears after the host reads status group b
// - over-temperature resets whole configuration and sets thermal flag
// - clear status raises thermal flag without touching configuration
// - open-wire conversion runs like a cell conversion with test currents
// - status group b reads revision and reserved bits in full
// - watchdog expiry after 2 s resets configuration bytes 0 to 3
// - expiry also resets bytes 4 and 5 when the timer is disabled
// - watchdog always runs, restarts on wake, releases its pin
// - enabled timer keeps discharge on, resets bytes 4 and 5 on firing
// - timeout codes select 0.5 to 120 minutes, 0 disabled
// - discharge timer restarts only on a completed configuration write
// - timer firing during a write still lets the new data load
// - decoder fail flag is set at power-on reset
// - timeout code reads back remaining-time bucket, 0 when idle
`timescale 1ns/1ps
module monitor_diag_watchdog_discharge_timer #(
   parameter int TICK_CYCLES = diag_pkg::TICK_CYC
) (
   // clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // asynchronous pins
   input  wire logic        wake_pin,
   input  wire logic        timer_enable_pin,
   input  wire logic        over_temp_pin,
   // measurement word from the converter chain
   input  wire logic [15:0] adc_word,
   // outputs
   output logic [11:0]      discharge_on,
   output logic             ow_source_en,
   output logic             ow_sink_en,
   output logic             conv_busy,
   output logic             watchdog_out_pin_o,
   output logic             watchdog_out_pin_oe
);
   typedef enum logic [0:0] {IDLE = 1'b0, CONV = 1'b1} conv_state_type;

   logic [2:0]  sync1_q, sync2_q, sync1_d, sync2_d;
   logic        wake_old_q, wake_old_d;
   logic        ot_old_q, ot_old_d;
   logic        ten_s, wake_s, ot_s, wake_evt, ot_evt;
   // synchroniser chains, one per pin
   assign sync1_d = {over_temp_pin, timer_enable_pin, wake_pin};
   assign sync2_d = sync1_q;
   assign wake_s = sync2_q[0];
   assign ten_s  = sync2_q[1];
   assign ot_s   = sync2_q[2];
   assign wake_old_d = wake_s;
   assign ot_old_d   = ot_s;
   assign wake_evt = wake_s & ~wake_old_q;
   assign ot_evt   = ot_s & ~ot_old_q;

   // apb decode
   logic        acc, wr_acc, rd_acc;
   logic [31:0] rdata_d;
   logic        err_d, rdy_d;
   logic [2:0]  mode_q, mode_d;
   logic [1:0]  pat_q, pat_d;
   logic        pup_q, pup_d;
   logic [31:0] cfg_lo_q, cfg_lo_d, st_lo_q, st_lo_d;
   logic [15:0] cfg_hi_q, cfg_hi_d, st_hi_q, st_hi_d;
   logic [4:0]  ridx_q, ridx_d;
   logic [15:0] res_q [diag_pkg::NWORDS];
   logic [15:0] res_d [diag_pkg::NWORDS];
   logic [11:0] hi_flags_q, hi_flags_d, lo_flags_q, lo_flags_d;
   logic        dec_fail_q, dec_fail_d, therm_q, therm_d;
   logic [3:0]  code_rb;
   logic        mapped;
   assign acc    = psel & penable & pready;
   assign wr_acc = acc & pwrite;
   assign rd_acc = acc & ~pwrite;
   assign mapped = (paddr[1:0] == 2'h0) && (paddr <= diag_pkg::TSTAT_OFS);

   // read mux and one wait state so read data comes from a flip-flop
   always_comb begin
      rdy_d   = psel & penable & ~pready;
      err_d   = psel & penable & ~pready & ~mapped;
      rdata_d = prdata;
      if (psel & penable & ~pready) begin
         unique case (paddr)
            diag_pkg::CMD_OFS:    rdata_d = {31'h0, conv_busy};
            diag_pkg::MODE_OFS:   rdata_d = {26'h0, pup_q, pat_q, mode_q};
            diag_pkg::CFG_LO_OFS: rdata_d = cfg_lo_q;
            diag_pkg::CFG_HI_OFS: rdata_d = {16'h0, code_rb, cfg_hi_q[11:0]};
            diag_pkg::STATB_OFS:  rdata_d = {dec_fail_q, therm_q, diag_pkg::RSVD_VALUE,
               diag_pkg::REV_VALUE, lo_flags_q, hi_flags_q};
            diag_pkg::RIDX_OFS:   rdata_d = {27'h0, ridx_q};
            diag_pkg::RDATA_OFS:  rdata_d = {16'h0, res_q[ridx_q]};
            diag_pkg::TSTAT_OFS:  rdata_d = {31'h0, watchdog_out_pin_oe};
            default:              rdata_d = 32'h0;
         endcase
      end
   end

   // command pulses
   logic [8:0] cmd;
   assign cmd = (wr_acc && paddr == diag_pkg::CMD_OFS) ? pwdata[8:0] : 9'h0;

   // prescaler and timers
   logic [15:0] pre_q, pre_d;
   logic        tick;
   logic [11:0] wd_q, wd_d;
   logic        wd_exp_q, wd_exp_d, wd_fire;
   logic [22:0] dt_q, dt_d;
   logic        dt_fire, dt_en;
   assign tick = (pre_q == 16'(TICK_CYCLES - 1));
   assign dt_en = ten_s && (cfg_hi_q[15:12] != 4'h0);
   assign wd_fire = tick && !wd_exp_q && (wd_q == 12'(diag_pkg::WDOG_TICKS - 1));
   assign dt_fire = tick && (dt_q == 23'h1);

   // watchdog and discharge counters
   always_comb begin
      pre_d    = tick ? 16'h0 : pre_q + 16'h1;
      wd_d     = wd_q;
      wd_exp_d = wd_exp_q;
      dt_d     = dt_q;
      if (wake_evt) begin
         wd_d     = 12'h0;
         wd_exp_d = 1'b0;
      end else if (wd_fire) begin
         wd_exp_d = 1'b1;
      end else if (tick && !wd_exp_q) begin
         wd_d = wd_q + 12'h1;
      end
      if (cmd[diag_pkg::CMD_WRITE_CONFIG_CMD] && ten_s && st_hi_q[15:12] != 4'h0)
         dt_d = 23'(diag_pkg::DISCHARGE_TIMEOUT_CODE_HALFMIN[st_hi_q[15:12]]) *
            23'(diag_pkg::HALFMIN_TICKS);
      else if (cmd[diag_pkg::CMD_WRITE_CONFIG_CMD] || ot_evt || !dt_en)
         dt_d = 23'h0;
      else if (tick && dt_q != 23'h0)
         dt_d = dt_q - 23'h1;
   end

   // remaining-time bucket readback
   always_comb begin
      code_rb = 4'h0;
      if (dt_en && dt_q != 23'h0) begin
         for (int c = 15; c >= 1; c--) begin
            if (dt_q <= 23'(diag_pkg::DISCHARGE_TIMEOUT_CODE_HALFMIN[c]) * 23'(diag_pkg::HALFMIN_TICKS))
               code_rb = 4'(c);
         end
      end
   end

   // configuration registers and staging
   always_comb begin
      cfg_lo_d = cfg_lo_q;
      cfg_hi_d = cfg_hi_q;
      st_lo_d  = st_lo_q;
      st_hi_d  = st_hi_q;
      mode_d   = mode_q;
      pat_d    = pat_q;
      pup_d    = pup_q;
      ridx_d   = ridx_q;
      if (wr_acc) begin
         unique case (paddr)
            diag_pkg::CFG_LO_OFS: st_lo_d = pwdata;
            diag_pkg::CFG_HI_OFS: st_hi_d = pwdata[15:0];
            diag_pkg::MODE_OFS: begin
               mode_d = pwdata[2:0];
               pat_d  = pwdata[4:3];
               pup_d  = pwdata[5];
            end
            diag_pkg::RIDX_OFS:
               ridx_d = (pwdata[4:0] < 5'(diag_pkg::NWORDS)) ? pwdata[4:0] : 5'h0;
            default: ;
         endcase
      end
      if (wd_fire) begin
         cfg_lo_d = diag_pkg::CFG_LO_RST;
         if (!dt_en)
            cfg_hi_d = diag_pkg::CFG_HI_RST;
      end
      if (dt_fire && dt_en)
         cfg_hi_d = diag_pkg::CFG_HI_RST;
      if (ot_evt) begin
         cfg_lo_d = diag_pkg::CFG_LO_RST;
         cfg_hi_d = diag_pkg::CFG_HI_RST;
      end
      if (cmd[diag_pkg::CMD_WRITE_CONFIG_CMD]) begin
         cfg_lo_d = st_lo_q;
         cfg_hi_d = st_hi_q;
      end
   end

   // conversion sequencer shared by normal, open-wire and self-test runs
   conv_state_type cst_q, cst_d;
   logic [11:0] cnt_q, cnt_d;
   logic [2:0]  kind_q, kind_d; // 0 cell,1 openw,2 st cell,3 st aux,4 st stat
   logic [15:0] pat_word;
   logic        done;
   always_comb begin
      unique case ({pat_q, mode_q == diag_pkg::MODE_27K, mode_q == diag_pkg::MODE_14K})
         4'b0110: pat_word = diag_pkg::PAT1_27K;
         4'b0101: pat_word = diag_pkg::PAT1_14K;
         4'b1010: pat_word = diag_pkg::PAT2_27K;
         4'b1001: pat_word = diag_pkg::PAT2_14K;
         default: pat_word = pat_q[1] ? diag_pkg::PAT2_SLOW : diag_pkg::PAT1_SLOW;
      endcase
   end
   assign done = (cst_q == CONV) && (cnt_q == 12'h1);

   always_comb begin
      cst_d  = cst_q;
      cnt_d  = cnt_q;
      kind_d = kind_q;
      unique case (cst_q)
         IDLE: begin
            if (cmd[7:3] != 5'h0) begin
               cst_d = CONV;
               cnt_d = 12'(diag_pkg::CONV_BASE_CYC) << mode_q;
               if (cmd[diag_pkg::CMD_CONV])       kind_d = 3'h0;
               else if (cmd[diag_pkg::CMD_OPENW]) kind_d = 3'h1;
               else if (cmd[diag_pkg::CMD_ST_CELL]) kind_d = 3'h2;
               else if (cmd[diag_pkg::CMD_ST_AUX])  kind_d = 3'h3;
               else                                 kind_d = 3'h4;
            end
         end
         CONV: begin
            cnt_d = cnt_q - 12'h1;
            if (done)
               cst_d = IDLE;
         end
      endcase
   end

   // result words: conversions, self-test patterns and clears
   always_comb begin
      for (int i = 0; i < diag_pkg::NWORDS; i++) begin
         res_d[i] = res_q[i];
         if (done) begin
            if (i < diag_pkg::AUX_BASE && kind_q <= 3'h1)
               res_d[i] = adc_word;
            if ((i < diag_pkg::AUX_BASE && kind_q == 3'h2) ||
                (i >= diag_pkg::AUX_BASE && i < diag_pkg::STA_BASE && kind_q == 3'h3) ||
                (i >= diag_pkg::STA_BASE && kind_q == 3'h4))
               res_d[i] = pat_word;
         end
         if (i < diag_pkg::AUX_BASE && cmd[diag_pkg::CMD_CLR_CELL])
            res_d[i] = diag_pkg::CLEARED_WORD;
         if (i >= diag_pkg::AUX_BASE && i < diag_pkg::STA_BASE &&
             cmd[diag_pkg::CMD_CLR_AUX])
            res_d[i] = diag_pkg::CLEARED_WORD;
         if (i >= diag_pkg::STA_BASE && cmd[diag_pkg::CMD_CLR_STAT])
            res_d[i] = diag_pkg::CLEARED_WORD;
      end
   end

   // status flags; a setting event wins over the read clear
   always_comb begin
      hi_flags_d = hi_flags_q;
      lo_flags_d = lo_flags_q;
      dec_fail_d = dec_fail_q;
      therm_d    = therm_q;
      if (rd_acc && paddr == diag_pkg::STATB_OFS)
         therm_d = 1'b0;
      if (cmd[diag_pkg::CMD_CLR_STAT]) begin
         hi_flags_d = 12'hfff;
         lo_flags_d = 12'hfff;
         dec_fail_d = 1'b1;
         therm_d    = 1'b1;
      end
      if (ot_evt)
         therm_d = 1'b1;
   end

   // output next values
   logic [11:0] dis_d;
   logic        src_d, snk_d, busy_d, wdo_d;
   assign dis_d  = cfg_hi_d[11:0];
   assign src_d  = (cst_d == CONV) && (kind_d == 3'h1) && pup_q;
   assign snk_d  = (cst_d == CONV) && (kind_d == 3'h1) && !pup_q;
   assign busy_d = (cst_d == CONV);
   assign wdo_d  = !wd_exp_d;
   assign watchdog_out_pin_o = 1'b0;

   // registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync1_q      <= 3'h0;
         sync2_q      <= 3'h0;
         wake_old_q   <= 1'b0;
         ot_old_q     <= 1'b0;
         prdata       <= 32'h0;
         pready       <= 1'b0;
         pslverr      <= 1'b0;
         pre_q        <= 16'h0;
         wd_q         <= 12'h0;
         wd_exp_q     <= 1'b0;
         dt_q         <= 23'h0;
         cfg_lo_q     <= diag_pkg::CFG_LO_RST;
         cfg_hi_q     <= diag_pkg::CFG_HI_RST;
         st_lo_q      <= diag_pkg::CFG_LO_RST;
         st_hi_q      <= diag_pkg::CFG_HI_RST;
         mode_q       <= 3'h0;
         pat_q        <= 2'h1;
         pup_q        <= 1'b0;
         ridx_q       <= 5'h0;
         cst_q        <= IDLE;
         cnt_q        <= 12'h0;
         kind_q       <= 3'h0;
         res_q        <= '{default: diag_pkg::CLEARED_WORD};
         hi_flags_q   <= 12'h0;
         lo_flags_q   <= 12'h0;
         dec_fail_q   <= 1'b1;
         therm_q      <= 1'b0;
         discharge_on <= 12'h0;
         ow_source_en <= 1'b0;
         ow_sink_en   <= 1'b0;
         conv_busy    <= 1'b0;
         watchdog_out_pin_oe <= 1'b1;
      end else begin
         sync1_q      <= sync1_d;
         sync2_q      <= sync2_d;
         wake_old_q   <= wake_old_d;
         ot_old_q     <= ot_old_d;
         prdata       <= rdata_d;
         pready       <= rdy_d;
         pslverr      <= err_d;
         pre_q        <= pre_d;
         wd_q         <= wd_d;
         wd_exp_q     <= wd_exp_d;
         dt_q         <= dt_d;
         cfg_lo_q     <= cfg_lo_d;
         cfg_hi_q     <= cfg_hi_d;
         st_lo_q      <= st_lo_d;
         st_hi_q      <= st_hi_d;
         mode_q       <= mode_d;
         pat_q        <= pat_d;
         pup_q        <= pup_d;
         ridx_q       <= ridx_d;
         cst_q        <= cst_d;
         cnt_q        <= cnt_d;
         kind_q       <= kind_d;
         res_q        <= res_d;
         hi_flags_q   <= hi_flags_d;
         lo_flags_q   <= lo_flags_d;
         dec_fail_q   <= dec_fail_d;
         therm_q      <= therm_d;
         discharge_on <= dis_d;
         ow_source_en <= src_d;
         ow_sink_en   <= snk_d;
         conv_busy    <= busy_d;
         watchdog_out_pin_oe <= wdo_d;
      end
   end
endmodule : monitor_diag_watchdog_discharge_timer

// file: tb/diag_checker_assertions.sv
/*
 port-level checks of the diagnostic block; bound to the design top and
 assumes its ports only
*/
`timescale 1ns/1ps
module diag_checker #(
   parameter int TICK_CYCLES = 4
) (
   // clock, reset, apb
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   // pins and outputs
   input wire logic        wake_pin,
   input wire logic        timer_enable_pin,
   input wire logic        over_temp_pin,
   input wire logic [15:0] adc_word,
   input wire logic [11:0] discharge_on,
   input wire logic        ow_source_en,
   input wire logic        ow_sink_en,
   input wire logic        conv_busy,
   input wire logic        watchdog_out_pin_o,
   input wire logic        watchdog_out_pin_oe
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // longest conversion is the base length at the slowest mode code
   localparam int CONV_MAX = diag_pkg::CONV_BASE_CYC << 7;
   logic [11:0] busy_len;
   // counts busy cycles so the upper bound needs no long delay range
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         busy_len <= 12'h0;
      else
         busy_len <= conv_busy ? busy_len + 12'h1 : 12'h0;
   end
   // access phase with its single wait state
   sequence s_wait;
      penable && !pready ##1 pready;
   endsequence
   sequence s_busy_run;
      conv_busy[*8] ##1 conv_busy[*4];
   endsequence
   property p_wait; psel && !penable |=> s_wait; endproperty
   property p_pulse; pready |=> !pready; endproperty
   property p_err; psel && penable && pready |-> pslverr == (paddr > 8'h1c || paddr[1:0] != 2'h0);
   endproperty
   property p_err_ready; pslverr |-> pready; endproperty
   property p_ow; ow_source_en || ow_sink_en |-> conv_busy && !(ow_source_en && ow_sink_en);
   endproperty
   property p_conv; $rose(conv_busy) |-> s_busy_run; endproperty
   property p_conv_max; conv_busy |-> busy_len < 12'(CONV_MAX); endproperty
   property p_trip; $rose(over_temp_pin) |-> ##[1:5] discharge_on == 12'h000; endproperty
   property p_pin; !watchdog_out_pin_o; endproperty
   property p_wake; $rose(wake_pin) |-> ##[1:5] watchdog_out_pin_oe; endproperty
   // labelled assertions
   a_wait: assert property (p_wait) else $error("pready not after one wait state");
   a_pulse: assert property (p_pulse) else $error("pready longer than one cycle");
   a_err: assert property (p_err) else $error("pslverr wrong for address");
   a_err_ready: assert property (p_err_ready) else $error("pslverr without pready");
   a_ow: assert property (p_ow) else $error("test current outside conversion");
   a_conv: assert property (p_conv) else $error("conversion length wrong");
   a_conv_max: assert property (p_conv_max) else $error("conversion too long");
   a_trip: assert property (p_trip) else $error("discharge not off on trip");
   a_pin: assert property (p_pin) else $error("watchdog pin driven high");
   a_wake: assert property (p_wake) else $error("wake did not restart watchdog");
endmodule : diag_checker

bind monitor_diag_watchdog_discharge_timer diag_checker #(.TICK_CYCLES(TICK_CYCLES))
   i_diag_checker (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .wake_pin(wake_pin), .timer_enable_pin(timer_enable_pin), .over_temp_pin(over_temp_pin),
   .adc_word(adc_word), .discharge_on(discharge_on), .ow_source_en(ow_source_en),
   .ow_sink_en(ow_sink_en), .conv_busy(conv_busy), .watchdog_out_pin_o(watchdog_out_pin_o),
   .watchdog_out_pin_oe(watchdog_out_pin_oe));

// file: tb/monitor_diag_watchdog_discharge_timer_bench.sv
/*
 self-checking bench of the diagnostic block: apb tasks and directed tests;
 assumes the wake source model and the bound checker
*/
`timescale 1ns/1ps
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin failures++; \
   $display("Error %s expected %h seen %h", nm, e, g); end end
module monitor_diag_watchdog_discharge_timer_bench;
   localparam int TICKS = 4;
   localparam int WD_WAIT = diag_pkg::WDOG_TICKS * TICKS + 200;
   logic        pclk, presetn, psel, penable, pwrite, ten, otp, wake_run, wake_pin;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [15:0] adc;
   logic [15:0] ow_end [2];
   logic [1:0]  ow;
   logic [11:0] dis;
   logic        pready, pslverr, er, src, snk, busy, wdo, wdoe;
   int          failures, tests_run;
   // clock
   always #50 pclk = ~pclk;
   monitor_diag_watchdog_discharge_timer #(.TICK_CYCLES(TICKS))
      i_monitor_diag_watchdog_discharge_timer (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .wake_pin(wake_pin), .timer_enable_pin(ten), .over_temp_pin(otp), .adc_word(adc),
      .discharge_on(dis), .ow_source_en(src), .ow_sink_en(snk), .conv_busy(busy),
      .watchdog_out_pin_o(wdo), .watchdog_out_pin_oe(wdoe));
   wake_source i_wake_source (.run(wake_run), .wake_pin(wake_pin));
   // one apb transfer, held until pready
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic word(input int i);
      apb(1'b1, diag_pkg::RIDX_OFS, 32'(i));
      apb(1'b0, diag_pkg::RDATA_OFS, 32'h0);
   endtask : word
   task automatic run_cmd(input int b);
      ow = 2'h0;
      apb(1'b1, diag_pkg::CMD_OFS, 32'h1 << b);
      // collect the test current outputs seen while the run is busy
      do begin
         @(posedge pclk);
         ow |= {src, snk};
      end while (busy !== 1'b0);
   endtask : run_cmd
   task automatic commit(input logic [31:0] lo, input logic [31:0] hi);
      apb(1'b1, diag_pkg::CFG_LO_OFS, lo);
      apb(1'b1, diag_pkg::CFG_HI_OFS, hi);
      apb(1'b1, diag_pkg::CMD_OFS, 32'h1 << diag_pkg::CMD_WRITE_CONFIG_CMD);
   endtask : commit
   function automatic logic [15:0] pat(input int m, input int p);
      if (p == 1)
         return m == 0 ? diag_pkg::PAT1_27K : m == 1 ? diag_pkg::PAT1_14K : diag_pkg::PAT1_SLOW;
      return m == 0 ? diag_pkg::PAT2_27K : m == 1 ? diag_pkg::PAT2_14K : diag_pkg::PAT2_SLOW;
   endfunction : pat
   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : tally_and_finish
   // watchdog against a hung run
   initial begin
      repeat (40000) @(posedge pclk);
      failures++;
      tally_and_finish();
   end
   // main sequence
   initial begin
      {pclk, presetn, psel, penable, pwrite, otp, paddr, pwdata, adc} = '0;
      ten = 1'b1;
      wake_run = 1'b1;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, diag_pkg::STATB_OFS, 32'h0);
      `CHK("decoder fail", 1'b1, rd[31])
      `CHK("thermal", 1'b0, rd[30])
      `CHK("rev rsvd", {diag_pkg::RSVD_VALUE, diag_pkg::REV_VALUE}, rd[29:24])
      apb(1'b0, 8'h20, 32'h0);
      `CHK("unmapped", 33'h1_0000_0000, {er, rd})
      apb(1'b0, diag_pkg::TSTAT_OFS, 32'h0);
      `CHK("watchdog alive", 1'b1, rd[0])
      $display("test reset done");
      for (int m = 0; m < 3; m++)
         for (int p = 1; p < 3; p++)
            for (int c = 0; c < 3; c++) begin
               apb(1'b1, diag_pkg::MODE_OFS, 32'(m) | 32'(p << 3));
               run_cmd(diag_pkg::CMD_ST_CELL + c);
               word(c == 0 ? 0 : c == 1 ? diag_pkg::AUX_BASE : diag_pkg::STA_BASE);
               `CHK("selftest", {16'h0, pat(m, p)}, rd)
            end
      $display("test selftest done");
      adc <= 16'h1234;
      for (int u = 1; u >= 0; u--) begin
         apb(1'b1, diag_pkg::MODE_OFS, 32'h8 | 32'(u << 5));
         repeat (2) run_cmd(diag_pkg::CMD_OPENW);
         `CHK("test current", {u == 1, u == 0}, ow)
         // sourced phase keeps cell 1, sunk phase keeps cell 12
         word((1 - u) * 11);
         `CHK("open wire word", 32'h1234, rd)
         ow_end[u] = rd[15:0];
      end
      `CHK("open end input", 1'b0, ow_end[1] == 16'h0 || ow_end[0] == 16'h0)
      $display("test open wire done");
      commit(32'ha5a5_a5a5, 32'h3abc);
      apb(1'b0, diag_pkg::CFG_HI_OFS, 32'h0);
      `CHK("cfg hi", {32'h3abc, 12'habc}, {rd, dis})
      run_cmd(diag_pkg::CMD_CLR_CELL);
      word(3);
      `CHK("cleared cell", 32'hffff, rd)
      run_cmd(diag_pkg::CMD_CLR_AUX);
      word(diag_pkg::AUX_BASE);
      `CHK("cleared aux", 32'hffff, rd)
      run_cmd(diag_pkg::CMD_CLR_STAT);
      word(diag_pkg::STA_BASE + 2);
      `CHK("cleared stat", 32'hffff, rd)
      apb(1'b0, diag_pkg::STATB_OFS, 32'h0);
      `CHK("flags set", {2'h3, diag_pkg::RSVD_VALUE, diag_pkg::REV_VALUE, 24'hffffff}, rd)
      apb(1'b0, diag_pkg::STATB_OFS, 32'h0);
      `CHK("thermal read clear", 1'b0, rd[30])
      apb(1'b0, diag_pkg::CFG_LO_OFS, 32'h0);
      `CHK("cfg kept", 32'ha5a5_a5a5, rd)
      $display("test clear done");
      otp <= 1'b1;
      repeat (8) @(posedge pclk);
      otp <= 1'b0;
      apb(1'b0, diag_pkg::CFG_LO_OFS, 32'h0);
      `CHK("trip cfg", {diag_pkg::CFG_LO_RST, 12'h0}, {rd, dis})
      apb(1'b0, diag_pkg::STATB_OFS, 32'h0);
      `CHK("trip flag", 1'b1, rd[30])
      $display("test thermal done");
      commit(32'ha5a5_a5a5, 32'h3abc);
      wake_run <= 1'b0;
      repeat (WD_WAIT) @(posedge pclk);
      apb(1'b0, diag_pkg::TSTAT_OFS, 32'h0);
      `CHK("expired", 2'h0, {rd[0], wdoe})
      apb(1'b0, diag_pkg::CFG_LO_OFS, 32'h0);
      `CHK("low bytes reset", diag_pkg::CFG_LO_RST, rd)
      apb(1'b0, diag_pkg::CFG_HI_OFS, 32'h0);
      `CHK("discharge held", {32'h3abc, 12'habc}, {rd, dis})
      ten <= 1'b0;
      wake_run <= 1'b1;
      repeat (20) @(posedge pclk);
      commit(32'ha5a5_a5a5, 32'h3abc);
      apb(1'b0, diag_pkg::CFG_HI_OFS, 32'h0);
      `CHK("timer off", {1'b1, 32'h0abc}, {wdoe, rd})
      wake_run <= 1'b0;
      repeat (WD_WAIT) @(posedge pclk);
      `CHK("high bytes reset", 12'h000, dis)
      $display("test watchdog done");
      tally_and_finish();
   end
endmodule : monitor_diag_watchdog_discharge_timer_bench

// file: tb/wake_source.sv
/*
 far-side wake source: toggles the wake line at an 800 ns period while run
 is high; assumes nothing of pclk and keeps its own phase
*/
`timescale 1ns/1ps
module wake_source (
   // control from the bench
   input  wire logic run,
   // wake line to the device
   output logic      wake_pin
);
   // link clock stands low between bursts, finishing any high half first
   initial begin
      wake_pin = 1'b0;
      #37;
      forever begin
         #400;
         if (run || wake_pin) wake_pin = ~wake_pin;
      end
   end
endmodule : wake_source
